// *** design/wdt24_watchdog.sv ***
// 24-bit reloadable down-counting watchdog
// Notes on behaviour
// R1: counter steps only on its own 50 kHz rc oscillator tick.
// R2: enabled by refresh instruction or always-on option; never turned off.
// R3: 24-bit down counter; reload is upper, high, low bytes.
// R4: first enable loads reload value, then counts down.
// R5: each refresh instruction reloads the counter from stored value.
// R6: refresh ignored once counter has reached 000002h.
// R7: software never programs reload below 000004h.
// R8: debug mode refreshes the counter continuously.
// R9: time-out at 000000h; response interrupt or short reset by option.
// R10: interrupt response raises interrupt and sets time-out flag.
// R11: after interrupt time-out counter wraps to ffffff, no reload.
// R12: interrupt response in stop mode: recovery, interrupt, both flags.
// R13: reset response in normal mode: short reset and time-out flag.
// R14: reset response in stop mode: recovery instead, both flags.
// R15: software unlocks with 55h then aah to control address.
// R16: unlock writes leave control bits unchanged, only advance lock.
// R17: software writes upper, high, low with nothing between.
// R18: any other write mid-sequence relocks until restarted, except a repeated 55h right after 55h.
// R19: locked after reset; relocks after low byte written.
// R20: control register read clears its upper four indicator bits.
// R21: reload byte reads return live counter bytes.
`timescale 1ns/1ns
`default_nettype none
module wdt24_watchdog
  import wdt24_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // rc oscillator tick, one cycle per oscillator period
  input wire logic rcTick,
  // options and modes
  input wire logic always_on_option,
  input wire logic timeout_response_option,
  input wire logic debugMode,
  input wire logic stopMode,
  // cpu side
  input wire logic watchdog_refresh_instruction,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  // externally sourced indicator sets
  input wire logic porSet,
  input wire logic extSet,
  // outputs
  output logic [7:0] regRdData,
  output logic irqReq,
  output logic shortReset,
  output logic stopRecovery,
  output logic enabled
);
  logic [23:0] count_r;
  logic [23:0] reloadValue;
  logic [3:0] flags_r;
  logic pendRefresh_r;
  logic started_r;
  logic highDone_r;
  wdt24_lock_t lock_r;
  wdt24_lock_t lock_nxt;
  logic wrCtl;
  logic rdCtl;
  logic wrUpper;
  logic wrHigh;
  logic wrLow;
  logic timeout;
  logic refreshOk;
  logic refreshTake;

  // register decode; upper and high reload bytes land only in their own lock step
  assign wrCtl = regWrite && regAddr == WDT24_ADDR_CTL;
  assign rdCtl = regRead && regAddr == WDT24_ADDR_CTL;
  assign wrUpper = regWrite && regAddr == WDT24_ADDR_UPPER && lock_r == WDT24_WANT_UPPER;
  assign wrHigh = regWrite && regAddr == WDT24_ADDR_HIGH && lock_r == WDT24_WANT_HIGH;
  // low byte is legal only as the write right after the high byte
  assign wrLow = regWrite && regAddr == WDT24_ADDR_LOW && highDone_r; // R17

  wdt24_reload_store u_store (
    .clk(clk),
    .resetn(resetn),
    .wrUpper(wrUpper),
    .wrHigh(wrHigh),
    .wrLow(wrLow),
    .wrData(regWrData),
    .reloadValue(reloadValue)
  );

  // lock sequence; any write off the expected step relocks, except a repeated 55h after 55h
  always_comb begin
    lock_nxt = lock_r;
    if (regWrite) begin
      lock_nxt = WDT24_LOCKED; // R18
      unique case (lock_r)
        WDT24_LOCKED: begin
          if (wrCtl && regWrData == WDT24_UNLOCK_FIRST) begin
            lock_nxt = WDT24_GOT55; // R16
          end
        end
        WDT24_GOT55: begin
          if (wrCtl && regWrData == WDT24_UNLOCK_SECOND) begin
            lock_nxt = WDT24_WANT_UPPER;
          end else if (wrCtl && regWrData == WDT24_UNLOCK_FIRST) begin
            lock_nxt = WDT24_GOT55;
          end
        end
        WDT24_WANT_UPPER: begin
          if (wrUpper) begin
            lock_nxt = WDT24_WANT_HIGH;
          end
        end
        WDT24_WANT_HIGH: begin
          lock_nxt = WDT24_LOCKED;
        end
      endcase
    end
  end

  // lock state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_r <= WDT24_LOCKED; // R19
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // high byte opens the one write slot for the low byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      highDone_r <= 1'b0;
    end else if (regWrite) begin
      highDone_r <= wrHigh; // R19
    end
  end

  // enable latch; only reset clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enabled <= 1'b0;
    end else if (watchdog_refresh_instruction || always_on_option) begin
      enabled <= 1'b1; // R2
    end
  end

  // refresh held until the next oscillator tick, as the count moves only then
  assign refreshOk = count_r > WDT24_NO_REFRESH || !started_r; // R6
  assign refreshTake = watchdog_refresh_instruction && refreshOk;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pendRefresh_r <= 1'b0;
    end else if (rcTick) begin
      pendRefresh_r <= refreshTake;
    end else if (refreshTake) begin
      pendRefresh_r <= 1'b1; // R5
    end
  end

  assign timeout = rcTick && started_r && count_r == WDT24_TERMINAL && !debugMode; // R9

  // first tick after enable marks the counter as started
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      started_r <= 1'b0;
    end else if (enabled && rcTick) begin
      started_r <= 1'b1; // R4
    end
  end

  // down counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= WDT24_RELOAD_RESET;
    end else if (enabled && rcTick) begin // R1
      if (!started_r) begin
        count_r <= reloadValue; // R4
      end else if (debugMode) begin
        count_r <= reloadValue; // R8
      end else if (pendRefresh_r && count_r > WDT24_NO_REFRESH) begin
        count_r <= reloadValue; // R5 R6
      end else if (count_r == WDT24_TERMINAL) begin
        count_r <= WDT24_COUNT_MAX; // R11
      end else begin
        count_r <= count_r - 24'h000001; // R3
      end
    end
  end

  // time-out responses, one-cycle pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= timeout && !timeout_response_option; // R10 R12
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shortReset <= 1'b0;
    end else begin
      shortReset <= timeout && timeout_response_option && !stopMode; // R13
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stopRecovery <= 1'b0;
    end else begin
      stopRecovery <= timeout && stopMode; // R12 R14
    end
  end

  // indicator bits {por, stop, timeout, ext}; set wins over read clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) flags_r <= 4'h0;
    else begin
      if (rdCtl) flags_r <= 4'h0; // R20
      if (porSet) flags_r[3] <= 1'b1;
      if (extSet) flags_r[0] <= 1'b1;
      if (timeout) begin
        flags_r[WDT24_CTL_TIMEOUT_BIT - 4] <= 1'b1; // R10 R13
        flags_r[3] <= 1'b0;
        flags_r[WDT24_CTL_STOP_BIT - 4] <= stopMode; // R12 R14
      end
    end
  end

  // registered read data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) regRdData <= 8'h00;
    else if (regRead) begin
      unique case (regAddr)
        WDT24_ADDR_CTL: regRdData <= {flags_r, 4'h0};
        WDT24_ADDR_UPPER: regRdData <= count_r[23:16]; // R21
        WDT24_ADDR_HIGH: regRdData <= count_r[15:8];
        WDT24_ADDR_LOW: regRdData <= count_r[7:0];
        default: regRdData <= 8'h00;
      endcase
    end
  end
endmodule : wdt24_watchdog
`default_nettype wire

// *** design/wdt24_pkg.sv ***
// package of constants for the 24-bit watchdog
package wdt24_pkg;
  localparam logic [11:0] WDT24_ADDR_CTL = 12'hff0;
  localparam logic [11:0] WDT24_ADDR_UPPER = 12'hff1;
  localparam logic [11:0] WDT24_ADDR_HIGH = 12'hff2;
  localparam logic [11:0] WDT24_ADDR_LOW = 12'hff3;
  localparam logic [7:0] WDT24_UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] WDT24_UNLOCK_SECOND = 8'haa;
  localparam logic [23:0] WDT24_RELOAD_RESET = 24'hffffff;
  localparam logic [23:0] WDT24_COUNT_MAX = 24'hffffff;
  localparam logic [23:0] WDT24_NO_REFRESH = 24'h000002;
  localparam logic [23:0] WDT24_TERMINAL = 24'h000000;
  localparam int WDT24_CTL_STOP_BIT = 6;
  localparam int WDT24_CTL_TIMEOUT_BIT = 5;
  localparam int WDT24_RC_FREQ_KHZ = 50;
  typedef enum logic [1:0] {
    WDT24_LOCKED = 2'b00,
    WDT24_GOT55 = 2'b01,
    WDT24_WANT_UPPER = 2'b11,
    WDT24_WANT_HIGH = 2'b10
  } wdt24_lock_t;
endpackage : wdt24_pkg

// *** design/wdt24_reload_store.sv ***
// reload value storage; three byte registers joined into the reload value
`timescale 1ns/1ns
`default_nettype none
module wdt24_reload_store
  import wdt24_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // byte writes
  input wire logic wrUpper,
  input wire logic wrHigh,
  input wire logic wrLow,
  input wire logic [7:0] wrData,
  // stored value
  output logic [23:0] reloadValue
);
  logic [7:0] upper_r;
  logic [7:0] high_r;
  logic [7:0] low_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upper_r <= WDT24_RELOAD_RESET[23:16];
      high_r <= WDT24_RELOAD_RESET[15:8];
      low_r <= WDT24_RELOAD_RESET[7:0];
    end else begin
      if (wrUpper) upper_r <= wrData;
      if (wrHigh) high_r <= wrData;
      if (wrLow) low_r <= wrData;
    end
  end

  // upper, high, low from msb down
  assign reloadValue = {upper_r, high_r, low_r}; // R3
endmodule : wdt24_reload_store
`default_nettype wire

// *** testbench/wdt24_rc_model.sv ***
// rc oscillator tick source feeding the watchdog
`timescale 1ns/1ns
`default_nettype none
module wdt24_rc_model #(parameter int DIV = 4) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // oscillator tick
  output logic rcTick
);
  int cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      rcTick <= 1'b0;
    end else begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      rcTick <= (cnt == DIV - 1);
    end
  end
endmodule : wdt24_rc_model
`default_nettype wire

// *** testbench/wdt24_watchdog_props.sv ***
// timing checks on the watchdog ports
`timescale 1ns/1ns
`default_nettype none
module wdt24_watchdog_props (
  // watched ports
  input wire logic clk,
  input wire logic resetn,
  input wire logic rcTick,
  input wire logic timeout_response_option,
  input wire logic debugMode,
  input wire logic stopMode,
  input wire logic watchdog_refresh_instruction,
  input wire logic irqReq,
  input wire logic shortReset,
  input wire logic stopRecovery,
  input wire logic enabled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  irq_single_a: assert property (irqReq |=> !irqReq)
    else $error("irq longer than one cycle");
  irq_cause_a: assert property (irqReq |-> !$past(timeout_response_option))
    else $error("irq with reset response");
  rst_cause_a: assert property (shortReset |-> $past(timeout_response_option) && !$past(stopMode))
    else $error("bad short reset");
  rec_cause_a: assert property (stopRecovery |-> $past(stopMode))
    else $error("recovery outside stop");
  stop_irq_a: assert property (stopRecovery && !$past(timeout_response_option) |-> irqReq)
    else $error("stop timeout without irq");
  tick_cause_a: assert property ((irqReq || shortReset || stopRecovery) |-> $past(rcTick))
    else $error("timeout off tick");
  enable_stick_a: assert property (enabled |=> enabled)
    else $error("enable dropped");
  enable_start_a: assert property (watchdog_refresh_instruction |-> ##[1:2] enabled)
    else $error("refresh did not enable");
  debug_quiet_a: assert property (debugMode && $past(debugMode) |-> !irqReq && !shortReset)
    else $error("timeout in debug");
endmodule : wdt24_watchdog_props
bind wdt24_watchdog wdt24_watchdog_props u_props (.clk(clk), .resetn(resetn), .rcTick(rcTick),
  .timeout_response_option(timeout_response_option), .debugMode(debugMode),
  .stopMode(stopMode), .watchdog_refresh_instruction(watchdog_refresh_instruction),
  .irqReq(irqReq), .shortReset(shortReset), .stopRecovery(stopRecovery), .enabled(enabled));
`default_nettype wire

// *** testbench/wdt24_watchdog_tb.sv ***
// self-checking bench for the 24-bit watchdog
`timescale 1ns/1ns
`default_nettype none
module wdt24_watchdog_tb;
  import wdt24_pkg::*;
  logic clk, resetn, rcTick, aoOpt, resOpt, debugMode, stopMode, refresh, regWrite, regRead;
  logic irqReq, shortReset, stopRecovery, enabled, porSet, extSet;
  logic [11:0] regAddr;
  logic [7:0] regWrData, regRdData;
  int mismatches, check_count, cycles;
  wdt24_rc_model #(.DIV(4)) rc (.clk(clk), .resetn(resetn), .rcTick(rcTick));
  wdt24_watchdog DUT (.clk(clk), .resetn(resetn), .rcTick(rcTick), .always_on_option(aoOpt),
    .timeout_response_option(resOpt), .debugMode(debugMode), .stopMode(stopMode),
    .watchdog_refresh_instruction(refresh), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .porSet(porSet), .extSet(extSet),
    .regRdData(regRdData), .irqReq(irqReq), .shortReset(shortReset),
    .stopRecovery(stopRecovery), .enabled(enabled));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) {regWrite, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clk) regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk) {regRead, regAddr} <= {1'b1, a};
    @(posedge clk) regRead <= 1'b0;
    @(negedge clk) chk(regRdData, exp);
  endtask : rd
  task automatic kick;
    @(posedge clk) refresh <= 1'b1;
    @(posedge clk) refresh <= 1'b0;
  endtask : kick
  task automatic hw_reset;
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
  endtask : hw_reset
  task automatic prog(input logic [23:0] v);
    wr(WDT24_ADDR_CTL, WDT24_UNLOCK_FIRST);
    wr(WDT24_ADDR_CTL, WDT24_UNLOCK_SECOND);
    wr(WDT24_ADDR_UPPER, v[23:16]);
    wr(WDT24_ADDR_HIGH, v[15:8]);
    wr(WDT24_ADDR_LOW, v[7:0]);
  endtask : prog
  task automatic relock_case;
    hw_reset();
    wr(WDT24_ADDR_UPPER, 8'h00);
    wr(WDT24_ADDR_CTL, WDT24_UNLOCK_FIRST);
    wr(WDT24_ADDR_HIGH, 8'h00);
    wr(WDT24_ADDR_CTL, WDT24_UNLOCK_SECOND);
    wr(WDT24_ADDR_UPPER, 8'h00);
    wr(WDT24_ADDR_LOW, 8'h08);
    rd(WDT24_ADDR_CTL, 8'h00);
    kick();
    repeat (12) @(posedge clk);
    rd(WDT24_ADDR_UPPER, 8'hff);
    prog(24'h000040);
    kick();
    repeat (20) @(posedge clk);
    rd(WDT24_ADDR_UPPER, 8'h00);
    rd(WDT24_ADDR_HIGH, 8'h00);
    $display("done relock");
  endtask : relock_case
  task automatic debug_case;
    int n;
    n = 0;
    hw_reset();
    debugMode <= 1'b1;
    aoOpt <= 1'b1;
    prog(24'h000004);
    chk({7'h0, enabled}, 8'h01);
    kick();
    repeat (200) @(negedge clk) n += irqReq | shortReset | stopRecovery;
    chk(8'(n), 8'h00);
    debugMode <= 1'b0;
    aoOpt <= 1'b0;
    $display("done debug");
  endtask : debug_case
  task automatic tmo_case(input logic opt, input logic stop);
    int n;
    n = 0;
    hw_reset();
    resOpt <= opt;
    stopMode <= stop;
    prog(24'h000008);
    kick();
    while (!(irqReq | shortReset | stopRecovery) && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk({5'h0, irqReq, shortReset, stopRecovery}, {5'h0, !opt, opt && !stop, stop});
    chk({7'h0, enabled}, 8'h01);
    rd(WDT24_ADDR_CTL, {1'b0, stop, 6'h20});
    rd(WDT24_ADDR_CTL, 8'h00);
    if (!opt && !stop) rd(WDT24_ADDR_UPPER, 8'hff);
    $display("done timeout opt=%0b stop=%0b", opt, stop);
  endtask : tmo_case
  task automatic flag_case;
    hw_reset();
    @(posedge clk) {porSet, extSet} <= 2'b11;
    @(posedge clk) {porSet, extSet} <= 2'b00;
    rd(WDT24_ADDR_CTL, 8'h90);
    rd(WDT24_ADDR_CTL, 8'h00);
    $display("done flags");
  endtask : flag_case
  initial begin
    {resetn, aoOpt, resOpt, debugMode, stopMode, refresh, regWrite, regRead} = 8'h00;
    {porSet, extSet} = 2'b00;
    {regAddr, regWrData, mismatches, check_count, cycles} = '0;
    relock_case();
    flag_case();
    debug_case();
    tmo_case(1'b0, 1'b0);
    tmo_case(1'b0, 1'b1);
    tmo_case(1'b1, 1'b0);
    tmo_case(1'b1, 1'b1);
    conclude();
  end
endmodule : wdt24_watchdog_tb
`default_nettype wire
